// ---- sss_pkg.sv ----
// Constants, register map and helpers for the serial port status block.
// Assumes one 25 MHz clock and an Avalon-MM master reaching the registers.
// Functional notes
// - In I2C mode stop-seen marks a last-detected stop; zero at reset and when disabled.
// - In I2C mode start-seen marks a last-detected start; zero at reset and when disabled.
// - Direction bit of last address match held until next start, stop or nack.
// - Buffer-full set when a received word lands in the buffer, clear when empty.
// - I2C transmit keeps buffer-full high until the transmission completes.
// - Eight-bit control register, reset zero: write_collision_flag, overflow, enable, polarity, mode.
// - Enabled SPI mode hands clock, data-out and data-in pins to the port.
package sss_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 6;
	localparam logic [5:0] OFS_BUF      = 6'h10;
	localparam logic [5:0] OFS_CTRL     = 6'h14;
	localparam logic [5:0] OFS_STAT     = 6'h18;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h1c;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [23:0] PAD_ZERO    = 24'h000000;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_WRITE_COLLISION_FLAG    = 7;
	localparam int CTRL_OVF     = 6;
	localparam int CTRL_EN      = 5;
	localparam int CTRL_CKP     = 4;
	localparam int I2C_MODE_BIT = 3;
	localparam int EV_W         = 5;
	localparam int EV_RX        = 0;
	localparam int EV_START     = 1;
	localparam int EV_STOP      = 2;
	localparam int EV_WRITE_COLLISION_FLAG      = 3;
	localparam int EV_OVF       = 4;
	localparam logic [EV_W-1:0] EV_ZERO = 5'h00;

	typedef enum {BUS_IDLE, BUS_ACK} sss_bus_type;

	function automatic logic is_i2c(input logic [3:0] mode);
		return mode[I2C_MODE_BIT];
	endfunction

endpackage

// ---- sss_flag_if.sv ----
// Carrier between the register front end and the status flag tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sss_flag_if;
	logic enable;
	logic i2c;
	logic start_ev;
	logic stop_ev;
	logic nack_ev;
	logic match_ev;
	logic match_rw;
	logic rx_load;
	logic buf_read;
	logic buf_write;
	logic tx_done;
	logic start_seen;
	logic stop_seen;
	logic read_write_flag;
	logic buffer_full_flag;
	logic tx_busy;

	modport ctrl (output enable, i2c, start_ev, stop_ev, nack_ev, match_ev, match_rw,
		rx_load, buf_read, buf_write, tx_done,
		input start_seen, stop_seen, read_write_flag, buffer_full_flag, tx_busy);
	modport flags (input enable, i2c, start_ev, stop_ev, nack_ev, match_ev, match_rw,
		rx_load, buf_read, buf_write, tx_done,
		output start_seen, stop_seen, read_write_flag, buffer_full_flag, tx_busy);
endinterface

// ---- sss_flags.sv ----
// Bus condition, direction and buffer-full tracking.
// Assumes events are single-cycle pulses on ref_clk from the shift engine.
`timescale 1ns/1ps
module sss_flags
	import sss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	sss_flag_if.flags fi
);

	logic start_q, start_d;
	logic stop_q,  stop_d;
	logic rw_q,    rw_d;
	logic busy_q,  busy_d;
	logic bf_q,    bf_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		start_d = start_q;
		stop_d  = stop_q;
		rw_d    = rw_q;
		busy_d  = busy_q;
		bf_d    = bf_q;
		if (fi.i2c)
		begin
			if (fi.start_ev)
			begin
				start_d = 1'b1;
				stop_d  = 1'b0;
				rw_d    = 1'b0;
			end
			else if (fi.stop_ev)
			begin
				stop_d  = 1'b1;
				start_d = 1'b0;
				rw_d    = 1'b0;
			end
			if (fi.nack_ev)
				rw_d = 1'b0;
			if (fi.match_ev)
				rw_d = fi.match_rw;
		end
		if (fi.tx_done)
			busy_d = 1'b0;
		if (fi.buf_write && fi.i2c)
			busy_d = 1'b1;
		// A read cannot empty the buffer while an I2C transmit is still shifting out (busy_q)
		if ((fi.buf_read && !busy_q) || fi.tx_done)
			bf_d = 1'b0;
		if (fi.rx_load || (fi.buf_write && fi.i2c))
			bf_d = 1'b1;
		if (!fi.enable)
		begin
			start_d = 1'b0;
			stop_d  = 1'b0;
			rw_d    = 1'b0;
			busy_d  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			start_q <= 1'b0;
			stop_q  <= 1'b0;
			rw_q    <= 1'b0;
			busy_q  <= 1'b0;
			bf_q    <= 1'b0;
		end
		else
		begin
			start_q <= start_d;
			stop_q  <= stop_d;
			rw_q    <= rw_d;
			busy_q  <= busy_d;
			bf_q    <= bf_d;
		end
	end

	assign fi.start_seen       = start_q;
	assign fi.stop_seen        = stop_q;
	assign fi.read_write_flag  = rw_q;
	assign fi.tx_busy          = busy_q;
	assign fi.buffer_full_flag = bf_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence tx_begin;
		fi.i2c && fi.enable && fi.buf_write;
	endsequence
	sequence tx_end;
		fi.tx_done && !fi.rx_load && !fi.buf_write;
	endsequence

	stop_last_a: assert property (fi.i2c && fi.enable && fi.stop_ev && !fi.start_ev
		|=> fi.stop_seen && !fi.start_seen) else $error("stop not flagged");
	start_last_a: assert property (fi.i2c && fi.enable && fi.start_ev
		|=> fi.start_seen && !fi.stop_seen) else $error("start not flagged");
	disable_clear_a: assert property (!fi.enable
		|=> !fi.start_seen && !fi.stop_seen) else $error("flags kept when off");
	rw_capture_a: assert property (fi.i2c && fi.enable && fi.match_ev
		|=> fi.read_write_flag == $past(fi.match_rw)) else $error("rw not taken");
	rw_hold_a: assert property (fi.enable && !fi.start_ev && !fi.stop_ev && !fi.nack_ev
		&& !fi.match_ev |=> $stable(fi.read_write_flag)) else $error("rw moved");
	rx_full_a: assert property (fi.rx_load |=> fi.buffer_full_flag)
		else $error("rx not full");
	tx_full_a: assert property (tx_begin ##1 !fi.tx_done |-> fi.buffer_full_flag)
		else $error("tx not full");
	tx_empty_a: assert property (tx_end |=> !fi.buffer_full_flag)
		else $error("tx end not empty");

endmodule // sss_flags

// ---- sss_port.sv ----
// Register front end of the serial port: control, buffer, status, interrupts.
// Assumes an Avalon-MM master on ref_clk and a shift engine on the same clock.
`timescale 1ns/1ps
module sss_port
	import sss_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [3:0]        avs_byteenable,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              start_det,
	input  wire logic              stop_det,
	input  wire logic              nack_det,
	input  wire logic              addr_match,
	input  wire logic              addr_rw,
	input  wire logic              address_update_flag,
	input  wire logic              rx_done,
	input  wire logic [7:0]        rx_word,
	input  wire logic              tx_done,
	output logic                   port_enable_bit,
	output logic                   clock_polarity_select,
	output logic      [3:0]        port_mode_select,
	output logic      [7:0]        tx_word,
	output logic                   tx_start,
	output logic                   serial_pins_sel,
	output logic                   irq
);

	sss_flag_if fi ();

	sss_bus_type          st_q, st_d;
	logic                 wait_q, wait_d;
	logic [31:0]          rdata_q, rdata_d;
	logic [7:0]           ctrl_q, ctrl_d;
	logic [7:0]           buf_q, buf_d;
	logic                 txs_q, txs_d;
	logic                 pins_q, pins_d;
	logic                 ua_q, ua_d;
	logic [EV_W-1:0]      ist_q, ist_d;
	logic [EV_W-1:0]      msk_q, msk_d;
	logic                 irq_q, irq_d;
	logic                 acc;
	logic                 wr_acc;
	logic                 rd_acc;
	logic                 buf_wr;
	logic                 buf_rd;
	logic                 en;
	logic                 i2c;
	logic                 write_collision_flag_ev;
	logic                 ovf_ev;
	logic                 rx_load;
	logic [EV_W-1:0]      ev;
	logic [7:0]           stat_vec;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a);
		logic [7:0] r;
		r = BYTE_ZERO;
		if (a == OFS_BUF)
			r = buf_q;
		else if (a == OFS_CTRL)
			r = ctrl_q;
		else if (a == OFS_STAT)
			r = stat_vec;
		else if (a == OFS_IRQ_STAT)
			r = {3'h0, ist_q};
		else if (a == OFS_IRQ_MASK)
			r = {3'h0, msk_q};
		return r;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		return a == o;
	endfunction

	// ------------------------------------------------------------
	// Flag tracker
	// ------------------------------------------------------------
	sss_flags u_flags
	(
		.ref_clk (ref_clk),
		.rst     (rst),
		.fi      (fi.flags)
	);

	assign en  = ctrl_q[CTRL_EN];
	assign i2c = is_i2c(ctrl_q[3:0]);

	// All flag bits come from flops of one edge, so a read sees one snapshot
	assign stat_vec = {2'h0, 1'b0, fi.stop_seen, fi.start_seen, fi.read_write_flag,
		ua_q, fi.buffer_full_flag};

	// ------------------------------------------------------------
	// Avalon slave: one wait state on every access
	// ------------------------------------------------------------
	always_comb
	begin
		st_d    = st_q;
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		case (st_q)
			BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					st_d    = BUS_ACK;
					wait_d  = 1'b0;
					rdata_d = {PAD_ZERO, read_mux(avs_address)};
				end
			end
			BUS_ACK:
				st_d = BUS_IDLE;
			default:
				st_d = BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q    <= BUS_IDLE;
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			st_q    <= st_d;
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Side effects only at the edge where the master sees waitrequest low
	assign acc    = (st_q == BUS_ACK);
	assign wr_acc = acc && avs_write && avs_byteenable[0];
	assign rd_acc = acc && avs_read;
	assign buf_wr = wr_acc && hit(avs_address, OFS_BUF);
	assign buf_rd = rd_acc && hit(avs_address, OFS_BUF);

	// ------------------------------------------------------------
	// Control, buffer and pin hand-over
	// ------------------------------------------------------------
	assign write_collision_flag_ev = buf_wr && fi.tx_busy;
	assign ovf_ev  = rx_done && en && fi.buffer_full_flag;
	// Word that overruns a full buffer is dropped; old data stays
	assign rx_load = rx_done && en && !fi.buffer_full_flag;

	always_comb
	begin
		ctrl_d = ctrl_q;
		buf_d  = buf_q;
		txs_d  = 1'b0;
		if (wr_acc && hit(avs_address, OFS_CTRL))
			ctrl_d = avs_writedata[7:0];
		if (write_collision_flag_ev)
			ctrl_d[CTRL_WRITE_COLLISION_FLAG] = 1'b1;
		if (ovf_ev)
			ctrl_d[CTRL_OVF] = 1'b1;
		if (buf_wr && !write_collision_flag_ev)
		begin
			buf_d = avs_writedata[7:0];
			txs_d = en;
		end
		if (rx_load)
			buf_d = rx_word;
		pins_d = en && !i2c;
		ua_d   = i2c && en && address_update_flag;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			buf_q  <= BYTE_ZERO;
			txs_q  <= 1'b0;
			pins_q <= 1'b0;
			ua_q   <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			buf_q  <= buf_d;
			txs_q  <= txs_d;
			pins_q <= pins_d;
			ua_q   <= ua_d;
		end
	end

	// ------------------------------------------------------------
	// Flag tracker hookup
	// ------------------------------------------------------------
	assign fi.enable    = en;
	assign fi.i2c       = i2c;
	assign fi.start_ev  = start_det;
	assign fi.stop_ev   = stop_det;
	assign fi.nack_ev   = nack_det;
	assign fi.match_ev  = addr_match;
	assign fi.match_rw  = addr_rw;
	assign fi.rx_load   = rx_load;
	assign fi.buf_read  = buf_rd;
	assign fi.buf_write = buf_wr && !write_collision_flag_ev && en;
	assign fi.tx_done   = tx_done;

	// ------------------------------------------------------------
	// Interrupts: sticky, write one to clear, new event wins
	// ------------------------------------------------------------
	always_comb
	begin
		ev           = EV_ZERO;
		ev[EV_RX]    = rx_load;
		ev[EV_START] = start_det && i2c && en;
		ev[EV_STOP]  = stop_det && i2c && en;
		ev[EV_WRITE_COLLISION_FLAG]  = write_collision_flag_ev;
		ev[EV_OVF]   = ovf_ev;
		ist_d        = ist_q;
		msk_d        = msk_q;
		if (wr_acc && hit(avs_address, OFS_IRQ_STAT))
			ist_d = ist_q & ~avs_writedata[EV_W-1:0];
		if (wr_acc && hit(avs_address, OFS_IRQ_MASK))
			msk_d = avs_writedata[EV_W-1:0];
		ist_d = ist_d | ev;
		irq_d = |(ist_d & msk_d);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ist_q <= EV_ZERO;
			msk_q <= EV_ZERO;
			irq_q <= 1'b0;
		end
		else
		begin
			ist_q <= ist_d;
			msk_q <= msk_d;
			irq_q <= irq_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign avs_readdata          = rdata_q;
	assign avs_waitrequest       = wait_q;
	assign port_enable_bit       = ctrl_q[CTRL_EN];
	assign clock_polarity_select = ctrl_q[CTRL_CKP];
	assign port_mode_select      = ctrl_q[3:0];
	assign tx_word               = buf_q;
	assign tx_start              = txs_q;
	assign serial_pins_sel       = pins_q;
	assign irq                   = irq_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence bus_req;
		(avs_read || avs_write) && st_q == BUS_IDLE;
	endsequence
	sequence ctrl_wr;
		wr_acc && hit(avs_address, OFS_CTRL) && !write_collision_flag_ev && !ovf_ev;
	endsequence

	ctrl_write_a: assert property (ctrl_wr |=> ctrl_q == $past(avs_writedata[7:0]))
		else $error("control write lost");
	write_collision_flag_set_a: assert property (write_collision_flag_ev |=> ctrl_q[CTRL_WRITE_COLLISION_FLAG])
		else $error("collision not set");
	ovf_keep_a: assert property (ovf_ev |=> ctrl_q[CTRL_OVF] && $stable(buf_q))
		else $error("overflow mishandled");
	pins_spi_a: assert property ((ctrl_wr and (avs_writedata[CTRL_EN]
		&& !avs_writedata[I2C_MODE_BIT])) |-> ##2 serial_pins_sel)
		else $error("pins not handed over");
	pins_off_a: assert property ((ctrl_wr and !avs_writedata[CTRL_EN]) |-> ##2 !serial_pins_sel)
		else $error("pins not released");
	stat_snap_a: assert property ((bus_req and (hit(avs_address, OFS_STAT) && avs_read))
		|=> avs_readdata[4:0] == $past(stat_vec[4:0])) else $error("status torn");
	bus_ack_a: assert property (bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bad wait timing");
	irq_level_a: assert property (ev[EV_RX] && msk_q[EV_RX] |=> irq)
		else $error("irq missing");

endmodule // sss_port

// ---- sss_engine_model.sv ----
// Behavioural shift engine facing an external I2C or SPI master.
// Assumes the testbench calls pulse() and sets tx_delay for slow or prompt transmits.
`timescale 1ns/1ps
module sss_engine_model
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic tx_start,
	output logic      start_det,
	output logic      stop_det,
	output logic      nack_det,
	output logic      addr_match,
	output logic      addr_rw,
	output logic      address_update_flag,
	output logic      rx_done,
	output logic [7:0] rx_word,
	output logic      tx_done
);
	int tx_delay = 3;
	int tx_cnt;

	initial
	begin
		{start_det, stop_det, nack_det, addr_match, addr_rw, rx_done} = 6'h00;
		address_update_flag = 1'b0;
		rx_word = 8'h00;
	end

	// ------------------------------------------------------------
	// Bus conditions and received words, one cycle each
	// ------------------------------------------------------------
	// Kinds: 0 start, 1 stop, 2 nack, 3 address match, 4 word received
	task automatic pulse(input int kind, input logic [7:0] data);
		@(posedge ref_clk);
		case (kind)
			0: start_det <= 1'b1;
			1: stop_det <= 1'b1;
			2: nack_det <= 1'b1;
			3:
			begin
				addr_match <= 1'b1;
				addr_rw    <= data[0];
			end
			default:
			begin
				rx_done <= 1'b1;
				rx_word <= data;
			end
		endcase
		@(posedge ref_clk);
		{start_det, stop_det, nack_det, addr_match, rx_done} <= 5'h00;
		// Data no longer valid: show the inverse so stale use shows up
		addr_rw <= ~data[0];
		rx_word <= ~data;
	endtask

	// Level the engine raises when the match address needs a new value
	task automatic set_ua(input logic v);
		@(posedge ref_clk);
		address_update_flag <= v;
	endtask

	// ------------------------------------------------------------
	// Transmit completes tx_delay cycles after it is started
	// ------------------------------------------------------------
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_cnt  <= 0;
			tx_done <= 1'b0;
		end
		else
		begin
			tx_done <= (tx_cnt == 1);
			if (tx_start)
				tx_cnt <= tx_delay;
			else if (tx_cnt > 0)
				tx_cnt <= tx_cnt - 1;
		end
	end
endmodule // sss_engine_model

// ---- sync_serial_status_flags_tb_top.sv ----
// Self-checking bench for the serial port register front end.
// Assumes sss_pkg, sss_flag_if, sss_flags, sss_port and the engine model are compiled first.
`timescale 1ns/1ps
module sync_serial_status_flags_tb_top
	import sss_pkg::*;
;
	logic              ref_clk        = 1'b0;
	logic              rst            = 1'b1;
	logic [ADDR_W-1:0] avs_address    = '0;
	logic              avs_read       = 1'b0;
	logic              avs_write      = 1'b0;
	logic [3:0]        avs_byteenable = 4'h1;
	logic [31:0]       avs_writedata  = 32'h00000000;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              start_det, stop_det, nack_det, addr_match, addr_rw;
	logic              address_update_flag, rx_done, tx_done, tx_start;
	logic [7:0]        rx_word, tx_word;
	logic              port_enable_bit, clock_polarity_select, serial_pins_sel, irq;
	logic [3:0]        port_mode_select;
	logic [31:0]       q;
	int                fail_count = 0;
	int                compares   = 0;
	int                n;

	always #20 ref_clk = ~ref_clk;

	sss_port u_sss_port (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .start_det(start_det), .stop_det(stop_det),
		.nack_det(nack_det), .addr_match(addr_match), .addr_rw(addr_rw),
		.address_update_flag(address_update_flag), .rx_done(rx_done), .rx_word(rx_word),
		.tx_done(tx_done), .port_enable_bit(port_enable_bit),
		.clock_polarity_select(clock_polarity_select), .port_mode_select(port_mode_select),
		.tx_word(tx_word), .tx_start(tx_start), .serial_pins_sel(serial_pins_sel), .irq(irq));

	sss_engine_model u_sss_engine_model (.ref_clk(ref_clk), .rst(rst), .tx_start(tx_start),
		.start_det(start_det), .stop_det(stop_det), .nack_det(nack_det),
		.addr_match(addr_match), .addr_rw(addr_rw), .address_update_flag(address_update_flag),
		.rx_done(rx_done), .rx_word(rx_word), .tx_done(tx_done));

	// ------------------------------------------------------------
	// Checking and Avalon-MM master tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Waitrequest and read data are taken at the same rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge ref_clk);
		avs_address    <= a;
		avs_writedata  <= {PAD_ZERO, d};
		avs_byteenable <= be;
		avs_read       <= !wr;
		avs_write      <= wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge ref_clk);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input string msg);
		bus(1'b0, a, BYTE_ZERO, 4'h1);
		chk(q, {PAD_ZERO, exp}, msg);
	endtask

	task automatic settle(input int cycles);
		repeat (cycles) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdc(OFS_CTRL, CTRL_RST, "control after reset");
		rdc(OFS_STAT, 8'h00, "status after reset");
		chk(serial_pins_sel, 1'b0, "pins after reset");
		$display("test reset done");

		wr(OFS_CTRL, 8'hdf);
		rdc(OFS_CTRL, 8'hdf, "control readback");
		chk({clock_polarity_select, port_mode_select}, 5'h1f, "polarity and mode");
		bus(1'b1, OFS_CTRL, 8'h00, 4'h0);
		rdc(OFS_CTRL, 8'hdf, "write without lane 0 ignored");
		rdc(6'h3c, 8'h00, "unmapped address");
		wr(OFS_CTRL, 8'h20);
		settle(2);
		chk({port_enable_bit, serial_pins_sel}, 2'h3, "spi pins to port");
		u_sss_engine_model.pulse(0, 8'h00);
		rdc(OFS_STAT, 8'h00, "start ignored in spi mode");
		wr(OFS_CTRL, 8'h00);
		settle(2);
		chk(serial_pins_sel, 1'b0, "pins back to gpio");
		$display("test control done");

		wr(OFS_CTRL, 8'h28);
		u_sss_engine_model.pulse(0, 8'h00);
		rdc(OFS_STAT, 8'h08, "start last");
		u_sss_engine_model.set_ua(1'b1);
		rdc(OFS_STAT, 8'h0a, "address update shown");
		u_sss_engine_model.set_ua(1'b0);
		u_sss_engine_model.pulse(1, 8'h00);
		rdc(OFS_STAT, 8'h10, "stop replaces start");
		u_sss_engine_model.pulse(3, 8'h01);
		rdc(OFS_STAT, 8'h14, "direction captured");
		u_sss_engine_model.pulse(2, 8'h00);
		rdc(OFS_STAT, 8'h10, "direction ends at nack");
		u_sss_engine_model.pulse(3, 8'h01);
		u_sss_engine_model.pulse(0, 8'h00);
		rdc(OFS_STAT, 8'h08, "direction ends at start");
		u_sss_engine_model.pulse(3, 8'h01);
		wr(OFS_CTRL, 8'h08);
		rdc(OFS_STAT, 8'h00, "flags cleared by disable");
		rdc(OFS_IRQ_STAT, 8'h06, "irq status start and stop");
		wr(OFS_IRQ_STAT, 8'h06);
		$display("test conditions done");

		wr(OFS_CTRL, 8'h20);
		wr(OFS_IRQ_MASK, 8'h01);
		u_sss_engine_model.pulse(4, 8'h5a);
		settle(2);
		chk(irq, 1'b1, "irq on word received");
		rdc(OFS_STAT, 8'h01, "buffer full");
		rdc(OFS_IRQ_STAT, 8'h01, "irq status word received");
		rdc(OFS_BUF, 8'h5a, "received word");
		rdc(OFS_STAT, 8'h00, "buffer empty after read");
		wr(OFS_IRQ_STAT, 8'h01);
		settle(2);
		chk(irq, 1'b0, "irq cleared");
		wr(OFS_IRQ_MASK, 8'h00);
		u_sss_engine_model.pulse(4, 8'ha5);
		u_sss_engine_model.pulse(4, 8'h3c);
		settle(2);
		chk(irq, 1'b0, "irq masked");
		rdc(OFS_CTRL, 8'h60, "overflow flagged");
		rdc(OFS_IRQ_STAT, 8'h11, "irq status word and overflow");
		rdc(OFS_BUF, 8'ha5, "overflowing word dropped");
		$display("test receive done");

		wr(OFS_CTRL, 8'h28);
		u_sss_engine_model.tx_delay = 30;
		wr(OFS_BUF, 8'hc3);
		settle(0);
		chk(tx_word, 8'hc3, "transmit word");
		rdc(OFS_STAT, 8'h01, "full while transmitting");
		wr(OFS_BUF, 8'h11);
		rdc(OFS_CTRL, 8'ha8, "write collision");
		n = 0;
		while (tx_done !== 1'b1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(tx_done, 1'b1, "transmit completes");
		settle(1);
		rdc(OFS_STAT, 8'h00, "empty after transmit");
		$display("test transmit done");
		tally_and_finish();
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule // sync_serial_status_flags_tb_top
